// ==== nic_pci_defs.svh ====
`ifndef NIC_PCI_DEFS_SVH
`define NIC_PCI_DEFS_SVH
// Register byte addresses
`define A_CMD 8'h00
`define A_STAT 8'h04
`define A_CLS 8'h08
`define A_CFG 8'h0c
`define A_DADDR 8'h10
`define A_DCTL 8'h14
`define A_RDAT 8'h18
// Command register bits
`define B_MWI 4
`define B_PER 6
`define B_SEE 8
// Status register bits
`define B_DPD 8
`define B_RTA 12
`define B_SSE 14
`define B_DPE 15
// Configure, cache line size and DMA control register fields
`define B_CMWI 0
`define B_CRA 2
`define B_CTW 3
`define F_TXM 15:8
`define F_RXM 23:16
`define F_CLS 7:0
`define F_LAT 15:8
`define F_LEN 15:0
`define F_KND 17:16
`define B_BUSY 31
`define B_MAB 30
// Bus commands on C/BE
`define C_MRM 4'hc
`define C_MRL 4'he
`define C_MW 4'h7
`define C_MWI 4'hf
`define BE_ALL 4'h0
// DMA kinds
`define K_TXD 2'h0
`define K_CTR 2'h1
`define K_CTW 2'h2
`define K_RXD 2'h3
// Cache line sizes in DWords and byte masks
`define CLS8 8'h08
`define CLS16 8'h10
`define MSK8 6'h1f
`define MSK16 6'h3f
// Clocks without DEVSEL before master abort
`define MABORT 3'h5
`define REG_RST 32'h0
`endif

// ==== nic_pci_master_target_if.sv ====
// Overview of operation
// RULE1: Target data parity error always sets status bit 15.
// RULE2: Target data parity error drives PERR only when command bit 6 set.
// RULE3: Target cycle is never cut short by a data parity error.
// RULE4: Target disconnects after each control_status_space or configuration access.
// RULE5: Address parity error without both enables sets bit 15 only, no SERR.
// RULE6: Address parity error with both enables sets bits 14, 15, SERR one clock.
// RULE7: After address error the device still claims and completes its cycle.
// RULE8: Address parity is checked on every bus transaction.
// RULE9: Commands: MRM data reads, MRL control reads, MW control writes, MW/MWI data.
// RULE10: Transmit read burst ends at byte-count limit and FIFO space.
// RULE11: Receive write burst ends at byte-count limit and FIFO threshold.
// RULE12: Write bursts hold IRDY with valid data each phase; target paces by TRDY.
// RULE13: Burst backs off when latency timer expired and grant removed.
// RULE14: Disconnect or retry re-initiates; target abort sets bit 12, no retry.
// RULE15: No DEVSEL means master abort, ending FRAME and IRDY as normal.
// RULE16: MWI moves whole lines, all byte enables, crosses only into whole lines.
// RULE17: MWI only if line 8/16, aligned, data and space, bit 4, config enable.
// RULE18: Lapsed MWI condition ends the cycle at line end, then re-evaluate.
// RULE19: MW at line boundary ends and restarts when terminate-on-line set.
// RULE20: Read align ends transmit reads at line boundaries when FIFO nearly full.
// RULE21: Initiator data parity error with enable: PERR, bit 8; reads also bit 15.
// RULE22: PCI ignored while bus_reset_n or power_good inactive; config reinitialized.
// RULE23: DMA configuration changes only while no DMA runs.
`timescale 1ns/10ps
`default_nettype none
`include "nic_pci_defs.svh"
module nic_pci_master_target_if
  import nic_pci_pkg::*;
(
  // AHB-Lite register port
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Bus reset and power state
  input wire logic bus_reset_n,
  input wire logic power_good,
  // PCI address/data and command
  input wire logic [31:0] ad,
  output logic [31:0] ad_drv,
  output logic ad_en,
  input wire logic [3:0] cbe_n,
  output logic [3:0] cbe_n_drv,
  input wire logic par,
  // PCI master control
  input wire logic frame_n,
  output logic frame_n_drv,
  input wire logic irdy_n,
  output logic irdy_n_drv,
  output logic mst_en,
  output logic req_n,
  input wire logic gnt_n,
  // PCI target control
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic stop_n,
  output logic trdy_n_drv,
  output logic devsel_n_drv,
  output logic stop_n_drv,
  output logic tgt_en,
  input wire logic tgt_hit,
  // Error lines
  output logic perr_n_drv,
  output logic perr_en,
  output logic serr_n_drv,
  output logic serr_en,
  // FIFO side
  input wire logic [7:0] tx_space,
  output logic [31:0] tx_data,
  output logic tx_push,
  input wire logic [7:0] rx_count,
  input wire logic [31:0] rx_data,
  output logic rx_pop
);
  mst_st_t m_st;
  tgt_st_t t_st;
  logic [2:0] rst_s_q, pg_s_q;
  logic pci_ok_q, wr_q, fr_prev_q, dchk_q, dtgt_q, achk_q, par_q, twr_q;
  logic [7:0] wa_q;
  logic [15:0] cmd_q, stat_q, clsr_q;
  logic [31:0] cfg_q, daddr_q, addr_q, ad_q, rdat_q, hrdata_q;
  logic [15:0] rem_q, cnt_q;
  logic [1:0] kind_q;
  logic [7:0] lat_q;
  logic [2:0] dvt_q;
  logic go_q, mwi_q, mab_q, frame_q, irdy_q, men_q, aen_q, req_q;
  logic [3:0] cbe_q;
  logic trdy_q, dsel_q, stop_q, ten_q, perr_q, serr_q, push_q, pop_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = a == r;
  endfunction

  // Register access decode
  wire logic ah_go = hsel && hready && htrans[1];
  wire logic m_idle = m_st == M_IDLE && !go_q;
  wire logic w_cmd = wr_q && hit(wa_q, `A_CMD);
  wire logic w_cfg = wr_q && m_idle && hit(wa_q, `A_CFG);
  wire logic w_cls = wr_q && m_idle && hit(wa_q, `A_CLS);
  wire logic w_dad = wr_q && m_idle && hit(wa_q, `A_DADDR);
  wire logic start = wr_q && m_idle && pci_ok_q && hit(wa_q, `A_DCTL);
  wire logic [15:0] st_clr = (wr_q && hit(wa_q, `A_STAT)) ? hwdata[15:0] : 16'h0;
  wire logic [7:0] ra = haddr[7:0];
  wire logic [31:0] rmux =
    hit(ra, `A_CMD) ? {16'h0, cmd_q} :
    hit(ra, `A_STAT) ? {16'h0, stat_q} :
    hit(ra, `A_CLS) ? {16'h0, clsr_q} :
    hit(ra, `A_CFG) ? cfg_q :
    hit(ra, `A_DADDR) ? daddr_q :
    hit(ra, `A_DCTL) ? {go_q, mab_q, 12'h0, kind_q, rem_q} :
    hit(ra, `A_RDAT) ? rdat_q : `REG_RST;

  // Burst limits and command choice
  wire logic is_rd = !kind_q[1];
  wire logic [7:0] cls = clsr_q[`F_CLS];
  wire logic cls_ok = cls == `CLS8 || cls == `CLS16;
  wire logic [5:0] lmsk = (cls == `CLS16) ? `MSK16 : `MSK8;
  wire logic [31:0] na = addr_q + 32'h4;
  // Next phase is the last word of its line, so ending here stops on the boundary
  wire logic [31:0] nn = addr_q + 32'h8;
  wire logic line_end = cls_ok && (nn[5:0] & lmsk) == 6'h0;
  wire logic at_line = cls_ok && (addr_q[5:0] & lmsk) == 6'h0;

  function automatic logic mwi_ok(input logic [15:0] r);
    mwi_ok = cls_ok && kind_q == `K_RXD && rx_count >= cls && r >= {8'h0, cls}
      && cmd_q[`B_MWI] && cfg_q[`B_CMWI];
  endfunction

  wire logic mwi_go = mwi_ok(rem_q) && at_line; // RULE17
  wire logic mwi_more = mwi_ok(rem_q - 16'h2); // RULE16
  wire logic [7:0] bmax = (kind_q == `K_TXD) ? cfg_q[`F_TXM] :
    (kind_q == `K_RXD) ? cfg_q[`F_RXM] : 8'h0;
  wire logic lim_end = bmax != 8'h0 && cnt_q + 16'h2 >= {8'h0, bmax}
    && (kind_q != `K_TXD || !cfg_q[`B_CRA] || line_end); // RULE10 RULE11 RULE20
  wire logic ff_end = (kind_q == `K_TXD) ? (tx_space <= 8'h1
    || (cfg_q[`B_CRA] && tx_space < cls && line_end)) // RULE10 RULE20
    : (kind_q == `K_RXD && rx_count <= 8'h1); // RULE11
  wire logic boff = lat_q >= clsr_q[`F_LAT] && gnt_n; // RULE13
  wire logic mw_end = !mwi_q && !is_rd && cfg_q[`B_CTW] && line_end; // RULE19
  wire logic mwi_end = mwi_q && !mwi_more; // RULE18
  wire logic end_nx = rem_q == 16'h2 || ((!mwi_q || line_end)
    && (lim_end || ff_end || boff || mw_end || mwi_end)); // RULE16
  wire logic [3:0] bcmd = (kind_q == `K_TXD) ? `C_MRM :
    (kind_q == `K_CTR) ? `C_MRL : mwi_go ? `C_MWI : `C_MW; // RULE9
  wire logic xfer = m_st == M_DATA && !devsel_n && !trdy_n;
  wire logic mab = m_st == M_DATA && devsel_n && dvt_q == `MABORT;
  wire logic tab = m_st == M_DATA && devsel_n && !stop_n;

  // Target and parity checking
  wire logic adr_ph = pci_ok_q && fr_prev_q && !frame_n; // RULE8
  wire logic mown = m_st == M_ADDR || m_st == M_DATA;
  wire logic claim = t_st == T_IDLE && adr_ph && tgt_hit && !mown; // RULE7
  wire logic txf = t_st == T_DATA && !irdy_n;
  wire logic rcv = pci_ok_q && ((txf && twr_q) || (xfer && is_rd));
  wire logic bad = par != par_q;
  wire logic dpe_t = dchk_q && dtgt_q && bad;
  wire logic dpe_m = dchk_q && !dtgt_q && bad;
  wire logic ape = achk_q && bad;
  wire logic pen = cmd_q[`B_PER];
  wire logic sen = cmd_q[`B_SEE] && pen;
  wire logic [15:0] st_set = {dpe_t || ape || (dpe_m && pen), ape && sen, 1'b0, tab,
    3'h0, dpe_m && pen, 8'h0}; // RULE1 RULE5 RULE6 RULE14 RULE21

  assign hreadyout = 1'b1 | wr_q & 1'b0 | hrdata_q[0] & 1'b0;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign ad_drv = ad_q;
  assign ad_en = aen_q;
  assign cbe_n_drv = cbe_q;
  assign frame_n_drv = frame_q;
  assign irdy_n_drv = irdy_q;
  assign mst_en = men_q;
  assign req_n = req_q;
  assign trdy_n_drv = trdy_q;
  assign devsel_n_drv = dsel_q;
  assign stop_n_drv = stop_q;
  assign tgt_en = ten_q;
  assign perr_n_drv = !perr_q;
  assign perr_en = perr_q;
  assign serr_n_drv = !serr_q;
  assign serr_en = serr_q;
  assign tx_data = rdat_q;
  assign tx_push = push_q;
  assign rx_pop = pop_q;

  // Reset and power-good qualifiers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_s_q <= 3'h0;
      pg_s_q <= 3'h0;
      pci_ok_q <= 1'b0;
    end
    else
    begin
      rst_s_q <= {rst_s_q[1:0], bus_reset_n};
      pg_s_q <= {pg_s_q[1:0], power_good};
      if (rst_s_q[2] == rst_s_q[1] && pg_s_q[2] == pg_s_q[1])
        pci_ok_q <= rst_s_q[2] && pg_s_q[2]; // RULE22
    end
  end

  // Register file
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h0;
      hrdata_q <= `REG_RST;
      cmd_q <= 16'h0;
      stat_q <= 16'h0;
      clsr_q <= 16'h0;
      cfg_q <= `REG_RST;
      daddr_q <= `REG_RST;
    end
    else
    begin
      wr_q <= ah_go && hwrite;
      wa_q <= haddr[7:0];
      if (ah_go && !hwrite)
        hrdata_q <= rmux;
      if (!pci_ok_q)
      begin
        cmd_q <= 16'h0; // RULE22
        stat_q <= 16'h0;
        clsr_q <= 16'h0;
        cfg_q <= `REG_RST;
        daddr_q <= `REG_RST;
      end
      else
      begin
        stat_q <= (stat_q & ~st_clr) | st_set;
        if (w_cmd)
          cmd_q <= hwdata[15:0];
        if (w_cls)
          clsr_q <= hwdata[15:0]; // RULE23
        if (w_cfg)
          cfg_q <= hwdata; // RULE23
        if (w_dad)
          daddr_q <= hwdata;
      end
    end
  end

  // Bus master
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      m_st <= M_IDLE;
      {go_q, mwi_q, mab_q, men_q, aen_q, push_q, pop_q} <= 7'h0;
      {frame_q, irdy_q, req_q} <= 3'h7;
      cbe_q <= 4'hf;
      ad_q <= `REG_RST;
      addr_q <= `REG_RST;
      rdat_q <= `REG_RST;
      {rem_q, cnt_q} <= 32'h0;
      kind_q <= `K_TXD;
      lat_q <= 8'h0;
      dvt_q <= 3'h0;
    end
    else
    begin
      push_q <= xfer && is_rd;
      pop_q <= xfer && !is_rd;
      if (start)
      begin
        go_q <= hwdata[`F_LEN] != 16'h0;
        mab_q <= 1'b0;
        rem_q <= hwdata[`F_LEN];
        kind_q <= hwdata[`F_KND];
        addr_q <= daddr_q;
      end
      if (mown)
        lat_q <= (lat_q == 8'hff) ? lat_q : lat_q + 8'h1;
      if (xfer)
      begin
        addr_q <= na;
        rem_q <= rem_q - 16'h1;
        cnt_q <= cnt_q + 16'h1;
        ad_q <= rx_data; // RULE12
        if (is_rd)
          rdat_q <= ad;
        if (rem_q == 16'h1)
          go_q <= 1'b0;
      end
      if (!pci_ok_q)
      begin
        m_st <= M_IDLE; // RULE22
        go_q <= 1'b0;
        {frame_q, irdy_q, req_q} <= 3'h7;
        {men_q, aen_q} <= 2'h0;
      end
      else
        case (m_st)
          M_IDLE:
            if (go_q)
            begin
              req_q <= 1'b0;
              m_st <= M_REQ;
            end
          M_REQ:
            if (!gnt_n && frame_n && irdy_n)
            begin
              frame_q <= 1'b0;
              {men_q, aen_q} <= 2'h3;
              ad_q <= addr_q;
              cbe_q <= bcmd; // RULE9
              mwi_q <= mwi_go;
              cnt_q <= 16'h0;
              lat_q <= 8'h0;
              m_st <= M_ADDR;
            end
          M_ADDR:
          begin
            irdy_q <= 1'b0; // RULE12
            frame_q <= rem_q == 16'h1 || (bmax == 8'h1 && !mwi_q); // RULE10 RULE11
            cbe_q <= `BE_ALL; // RULE16
            ad_q <= rx_data;
            aen_q <= !is_rd;
            dvt_q <= 3'h0;
            m_st <= M_DATA;
          end
          M_DATA:
          begin
            dvt_q <= devsel_n ? dvt_q + 3'h1 : 3'h0;
            if (mab || tab)
            begin
              {frame_q, irdy_q} <= 2'h3; // RULE15
              go_q <= 1'b0; // RULE14
              mab_q <= mab;
              m_st <= M_TURN;
            end
            else if (!stop_n || (xfer && frame_q))
            begin
              {frame_q, irdy_q} <= 2'h3; // RULE14
              m_st <= M_TURN;
            end
            else if (xfer)
              frame_q <= end_nx; // RULE10 RULE11 RULE13 RULE18 RULE19
          end
          M_TURN:
          begin
            {men_q, aen_q} <= 2'h0;
            req_q <= !go_q;
            m_st <= go_q ? M_REQ : M_IDLE; // RULE14
          end
          default:
            m_st <= M_IDLE;
        endcase
    end
  end

  // Target, parity and system error
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t_st <= T_IDLE;
      {trdy_q, dsel_q, stop_q} <= 3'h7;
      {ten_q, twr_q, perr_q, serr_q} <= 4'h0;
      {fr_prev_q, dchk_q, dtgt_q, achk_q, par_q} <= 5'h10;
    end
    else
    begin
      fr_prev_q <= frame_n;
      par_q <= ^{ad, cbe_n};
      dchk_q <= rcv;
      dtgt_q <= txf;
      achk_q <= adr_ph; // RULE8
      perr_q <= (dpe_t || dpe_m) && pen; // RULE2 RULE21
      serr_q <= ape && sen; // RULE5 RULE6
      case (t_st)
        T_IDLE:
          if (claim)
          begin
            {trdy_q, dsel_q, stop_q} <= 3'h0; // RULE4
            ten_q <= 1'b1;
            twr_q <= cbe_n[0];
            t_st <= T_DATA;
          end
        T_DATA:
          if (txf || !pci_ok_q)
          begin
            {trdy_q, dsel_q, stop_q} <= 3'h7; // RULE3
            t_st <= T_REL;
          end
        T_REL:
        begin
          ten_q <= 1'b0;
          t_st <= T_IDLE;
        end
        default:
          t_st <= T_IDLE;
      endcase
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_dpe_tgt;
    dpe_t |=> stat_q[`B_DPE];
  endproperty
  a_dpe_tgt: assert property (p_dpe_tgt) else $error("target parity flag not set"); // RULE1
  property p_perr_gate;
    dpe_t |=> perr_en == $past(pen);
  endproperty
  a_perr_gate: assert property (p_perr_gate) else $error("PERR gating wrong"); // RULE2
  property p_no_cut;
    (t_st == T_DATA && irdy_n && pci_ok_q) |=> t_st == T_DATA && !stop_n_drv;
  endproperty
  a_no_cut: assert property (p_no_cut) else $error("target cycle cut short"); // RULE3
  property p_disc;
    claim |=> !stop_n_drv && !trdy_n_drv && !devsel_n_drv;
  endproperty
  a_disc: assert property (p_disc) else $error("no disconnect"); // RULE4
  property p_serr_off;
    (ape && !sen) |=> !serr_en && stat_q[`B_DPE];
  endproperty
  a_serr_off: assert property (p_serr_off) else $error("SERR without enables"); // RULE5
  property p_serr_one;
    (ape && sen) |=> serr_en && stat_q[`B_SSE] ##1 !serr_en;
  endproperty
  a_serr_one: assert property (p_serr_one) else $error("SERR not one clock"); // RULE6
  property p_claim;
    claim |=> t_st == T_DATA ##1 ten_q;
  endproperty
  a_claim: assert property (p_claim) else $error("cycle not claimed"); // RULE7
  property p_cmd_tx;
    (m_st == M_ADDR && kind_q == `K_TXD) |-> cbe_n_drv == `C_MRM;
  endproperty
  a_cmd_tx: assert property (p_cmd_tx) else $error("wrong read command"); // RULE9
  property p_irdy;
    m_st == M_DATA |-> !irdy_n_drv && mst_en;
  endproperty
  a_irdy: assert property (p_irdy) else $error("IRDY dropped in burst"); // RULE12
  property p_tabort;
    (tab && pci_ok_q) |=> stat_q[`B_RTA] && !go_q ##1 m_st == M_IDLE;
  endproperty
  a_tabort: assert property (p_tabort) else $error("target abort retried"); // RULE14
  property p_mabort;
    (mab && pci_ok_q) |=> frame_n_drv && irdy_n_drv;
  endproperty
  a_mabort: assert property (p_mabort) else $error("master abort not ended"); // RULE15
  property p_mwi_be;
    (m_st == M_DATA && mwi_q) |-> cbe_n_drv == `BE_ALL;
  endproperty
  a_mwi_be: assert property (p_mwi_be) else $error("MWI byte enables"); // RULE16
  property p_par_init;
    (dpe_m && pen && pci_ok_q) |=> perr_en && stat_q[`B_DPD] && stat_q[`B_DPE];
  endproperty
  a_par_init: assert property (p_par_init) else $error("initiator parity not flagged"); // RULE21

  c_burst: cover property (xfer && !is_rd ##1 xfer ##1 xfer);
  c_claim: cover property (claim ##1 txf);
  c_serr: cover property (ape && sen);
  c_mwi: cover property (m_st == M_ADDR && cbe_n_drv == `C_MWI);
endmodule
`default_nettype wire

// ==== nic_pci_master_target_if_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "nic_pci_defs.svh"
module nic_pci_master_target_if_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ad_drv, m_ad, t_ad = 32'h0;
  logic [31:0] pat = 32'h3c3c_a5a5;
  logic [1:0] htrans = 2'h0, mode = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic bus_reset_n = 1'b1, power_good = 1'b1, ad_en, mst_en, req_n, gnt_n = 1'b1;
  logic frame_n_drv, irdy_n_drv, trdy_n_drv, devsel_n_drv, stop_n_drv, tgt_en;
  logic perr_en, serr_en, tx_push, rx_pop, m_oe, m_devsel, m_trdy, m_stop, slow = 1'b0;
  logic t_frame = 1'b1, t_irdy = 1'b1, t_oe = 1'b0, tgt_hit = 1'b0, fr_p = 1'b1;
  logic par_q = 1'b0, par_flip = 1'b0, pre = 1'b0;
  logic [31:0] a_seen = 32'h0;
  logic [3:0] cbe_n_drv, t_cbe = 4'h0, cmd = 4'h0;
  logic [3:0] cmds [4] = '{`C_MRM, `C_MRL, `C_MW, `C_MW};
  logic [7:0] tx_space = 8'h40, rx_count = 8'h10, rx_ptr = 8'h0;
  logic [7:0] n_adr = 8'h0, n_wd = 8'h0, n_perr = 8'h0, n_serr = 8'h0;
  int n_mismatch = 0, n_compared = 0;
  wire logic [31:0] ad_w, rx_data;
  wire logic [3:0] cbe_w;
  wire logic frame_w, irdy_w, trdy_w, devsel_w, stop_w, par_w;
  // Shared lines resolved from all enables; a released ad shows a toggling pattern
  assign frame_w = mst_en ? frame_n_drv : t_frame;
  assign irdy_w = mst_en ? irdy_n_drv : t_irdy;
  assign cbe_w = mst_en ? cbe_n_drv : t_cbe;
  assign ad_w = ad_en ? ad_drv : m_oe ? m_ad : t_oe ? t_ad : pat;
  assign trdy_w = tgt_en ? trdy_n_drv : m_trdy;
  assign devsel_w = tgt_en ? devsel_n_drv : m_devsel;
  assign stop_w = tgt_en ? stop_n_drv : m_stop;
  assign par_w = par_q ^ par_flip;
  assign rx_data = {24'ha5a5a5, rx_ptr};
  nic_pci_master_target_if DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .bus_reset_n, .power_good,
    .ad(ad_w), .ad_drv, .ad_en, .cbe_n(cbe_w), .cbe_n_drv, .par(par_w), .frame_n(frame_w),
    .frame_n_drv, .irdy_n(irdy_w), .irdy_n_drv, .mst_en, .req_n, .gnt_n, .trdy_n(trdy_w),
    .devsel_n(devsel_w), .stop_n(stop_w), .trdy_n_drv, .devsel_n_drv, .stop_n_drv, .tgt_en,
    .tgt_hit, .perr_n_drv(), .perr_en, .serr_n_drv(), .serr_en, .tx_space, .tx_data(),
    .tx_push, .rx_count, .rx_data, .rx_pop);
  pci_mem_model mem_i (.clk(hclk), .frame_n(frame_w | ~mst_en), .irdy_n(irdy_w | ~mst_en),
    .ad(ad_w), .cbe_n(cbe_w), .mode, .slow, .devsel_n(m_devsel), .trdy_n(m_trdy),
    .stop_n(m_stop), .ad_out(m_ad), .ad_oe(m_oe));
  initial
    forever #5 hclk = ~hclk;
  // Parity follows the bus one clock late; grant held through own bursts unless pre is set
  always @(posedge hclk)
  begin
    pat <= ~pat;
    par_q <= ^{ad_w, cbe_w};
    fr_p <= frame_w;
    gnt_n <= (req_n & ~mst_en) | (pre & mst_en);
    n_perr <= n_perr + {7'h0, perr_en};
    n_serr <= n_serr + {7'h0, serr_en};
    n_wd <= n_wd + {7'h0, tx_push} + {7'h0, rx_pop};
    rx_ptr <= rx_ptr + {7'h0, rx_pop};
    if (mst_en && fr_p && !frame_w)
    begin
      n_adr <= n_adr + 8'h1;
      a_seen <= ad_w;
      cmd <= cbe_n_drv;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task give_up;
    n_mismatch++;
    $display("wait ran out at %0t", $time);
    tally_and_finish();
  endtask
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task hwait;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 40);
    if (i >= 40)
      give_up();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwait();
    d = hrdata;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d, e);
  endtask
  // One single-phase write from the testbench as initiator
  task tcyc(input logic hit, cl, ba, bd);
    t_frame <= 1'b0;
    t_oe <= 1'b1;
    t_ad <= 32'h0000_0040;
    t_cbe <= 4'h7;
    tgt_hit <= hit;
    tick(1);
    t_frame <= 1'b1;
    t_irdy <= 1'b0;
    t_ad <= 32'h1234_5678;
    t_cbe <= 4'h0;
    tgt_hit <= 1'b0;
    par_flip <= ba;
    #1 check({28'h0, devsel_n_drv, trdy_n_drv, stop_n_drv, tgt_en}, {28'h0, cl ? 4'h1 : 4'he});
    tick(1);
    t_irdy <= 1'b1;
    t_oe <= 1'b0;
    par_flip <= bd;
    tick(1);
    par_flip <= 1'b0;
    tick(6);
  endtask
  // Start a transfer at address 0 and wait for it to finish
  task dma(input logic [1:0] k, input logic [15:0] n, input logic [3:0] c,
    input logic [7:0] na, nw, output logic [31:0] d);
    logic [7:0] a0, w0;
    int i;
    a0 = n_adr;
    w0 = n_wd;
    wr(`A_DADDR, 32'h0);
    wr(`A_DCTL, {14'h0, k, n});
    tick(1);
    i = 0;
    do
    begin
      rd(`A_DCTL, d);
      i++;
    end
    while (d[31] !== 1'b0 && i < 60);
    if (i >= 60)
      give_up();
    check({28'h0, cmd}, {28'h0, c});
    check({24'h0, n_adr - a0}, {24'h0, na});
    check({24'h0, n_wd - w0}, {24'h0, nw});
  endtask
  initial
  begin
    logic [31:0] d;
    tick(2);
    hresetn <= 1'b1;
    tick(6);
    rc(`A_STAT, `REG_RST);
    wr(8'h40, 32'hffff_ffff);
    rc(8'h40, 32'h0);
    wr(`A_CLS, 32'h0000_ff08);
    $display("test registers done");
    tcyc(1'b1, 1'b1, 1'b0, 1'b1);
    rc(`A_STAT, 32'h0000_8000);
    check({24'h0, n_perr}, 32'h0);
    wr(`A_STAT, 32'h0000_f100);
    wr(`A_CMD, 32'h0000_0040);
    tcyc(1'b1, 1'b1, 1'b0, 1'b1);
    check({24'h0, n_perr}, 32'h1);
    wr(`A_STAT, 32'h0000_f100);
    tcyc(1'b0, 1'b0, 1'b1, 1'b0);
    rc(`A_STAT, 32'h0000_8000);
    check({24'h0, n_serr}, 32'h0);
    wr(`A_STAT, 32'h0000_f100);
    wr(`A_CMD, 32'h0000_0140);
    tcyc(1'b1, 1'b1, 1'b1, 1'b0);
    rc(`A_STAT, 32'h0000_c000);
    check({24'h0, n_serr}, 32'h1);
    wr(`A_STAT, 32'h0000_f100);
    $display("test target done");
    slow <= 1'b1;
    wr(`A_CFG, 32'h0002_0200);
    dma(`K_RXD, 16'h5, `C_MW, 8'h3, 8'h5, d);
    dma(`K_TXD, 16'h5, `C_MRM, 8'h3, 8'h5, d);
    slow <= 1'b0;
    wr(`A_CFG, 32'h0);
    for (int k = 3; k >= 0; k--)
      dma(2'(k), 16'h2, cmds[k], 8'h1, 8'h2, d);
    wr(`A_CLS, 32'h0000_0208);
    pre <= 1'b1;
    dma(`K_RXD, 16'h8, `C_MW, 8'h3, 8'h8, d);
    pre <= 1'b0;
    wr(`A_CLS, 32'h0000_ff08);
    $display("test commands done");
    wr(`A_CFG, 32'h0000_0001);
    wr(`A_CMD, 32'h0000_0050);
    dma(`K_RXD, 16'h8, `C_MWI, 8'h1, 8'h8, d);
    wr(`A_CMD, 32'h0000_0040);
    dma(`K_RXD, 16'h8, `C_MW, 8'h1, 8'h8, d);
    wr(`A_CFG, 32'h0000_0008);
    dma(`K_RXD, 16'h10, `C_MW, 8'h2, 8'h10, d);
    check(a_seen, 32'h0000_0020);
    wr(`A_CFG, 32'h0);
    $display("test write commands done");
    mode <= 2'h3;
    dma(`K_CTW, 16'h2, `C_MW, 8'h2, 8'h2, d);
    mode <= 2'h2;
    dma(`K_CTW, 16'h2, `C_MW, 8'h1, 8'h0, d);
    rc(`A_STAT, 32'h0000_1000);
    mode <= 2'h1;
    dma(`K_CTW, 16'h2, `C_MW, 8'h1, 8'h0, d);
    check({31'h0, d[30]}, 32'h1);
    mode <= 2'h0;
    $display("test terminations done");
    wr(`A_CMD, 32'h0000_0150);
    power_good <= 1'b0;
    tick(6);
    tcyc(1'b1, 1'b0, 1'b0, 1'b0);
    power_good <= 1'b1;
    tick(6);
    rc(`A_CMD, 32'h0);
    wr(`A_CMD, 32'h0000_0040);
    bus_reset_n <= 1'b0;
    tick(6);
    bus_reset_n <= 1'b1;
    tick(6);
    rc(`A_CMD, 32'h0);
    $display("test power done");
    tally_and_finish();
  end
  initial
  begin
    #1000000;
    give_up();
  end
endmodule
`default_nettype wire

// ==== nic_pci_pkg.sv ====
package nic_pci_pkg;
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} mst_st_t;
  typedef enum logic [1:0] {T_IDLE, T_DATA, T_REL} tgt_st_t;
endpackage

// ==== pci_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pci_mem_model
(
  // Clock and initiator lines
  input wire logic clk,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  // Mode 0 normal, 1 no claim, 2 target abort, 3 disconnect
  input wire logic [1:0] mode,
  input wire logic slow,
  // Target replies
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n,
  output logic [31:0] ad_out,
  output logic ad_oe
);
  logic [31:0] mem [32];
  logic [4:0] idx_q = 5'h0;
  logic rd_q = 1'b0, act_q = 1'b0, fr_q = 1'b1, wt_q = 1'b0, dn_q = 1'b0, claim;
  always @(posedge clk)
  begin
    fr_q <= frame_n;
    wt_q <= slow & ~wt_q;
    if (fr_q && !frame_n)
    begin
      act_q <= 1'b1;
      dn_q <= 1'b0;
      idx_q <= ad[6:2];
      rd_q <= ~cbe_n[0];
    end
    else if (act_q && !irdy_n && !trdy_n)
    begin
      if (!rd_q)
        mem[idx_q] <= ad;
      idx_q <= idx_q + 5'h1;
      act_q <= ~frame_n;
      dn_q <= mode[0];
    end
    else if (frame_n && irdy_n)
      act_q <= 1'b0;
  end
  // Slow mode holds TRDY off every other clock, one wait between data phases
  assign claim = act_q && (mode == 2'h0 || mode == 2'h3);
  assign devsel_n = ~claim;
  assign trdy_n = ~(claim && !wt_q && !dn_q);
  assign stop_n = ~(act_q && mode[1]);
  assign ad_out = mem[idx_q];
  assign ad_oe = claim && rd_q;
endmodule
`default_nettype wire
